//--- rtl/adcseq_core.sv
// Conversion sequencer for a sigma-delta analog-to-digital converter.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - A software write of one to the start flag begins a conversion of the selected input.
// - The start flag reads one for as long as a conversion is underway.
// - A single-shot conversion takes exactly 5129 clock cycles until the result is ready.
// - Starting from powered down adds 40 power-up cycles before the 5129-cycle conversion.
// - The 13-bit result goes to the high byte bits 7:0 and the low byte bits 7:3.
// - Each completed conversion sends a completion interrupt request.
// - The start flag clears to zero when a single-shot conversion finishes.
// - After 160 consecutive idle cycles the converter powers down by itself.
// - Continuous mode converts repeatedly and each result overwrites the previous one.
// - Continuous mode raises the completion request after every conversion.
// - The three-bit buffer mode field picks single-ended or differential, buffered or not.
// - The reference select pair picks the internal reference level or disables it.
// - The reference is driven to its pin when asked, and only while the reference is enabled.
// - Resolution is 11 bits differential and 10 bits single-ended.
// - A pin switched to its alternate function has its digital input and driver disabled.
// - The multiplexer selects one of eight pins or the temperature sensor.
module adcseq_core #(
  parameter int unsigned CONV_LEN = adcseq_pkg::CONV_CYCLES
) (
  input wire logic clk, // System clock, 125 MHz.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic start_write, // One-cycle pulse: software writes one to the start flag.
  input wire adcseq_pkg::adcseq_cfg_s cfg, // Software configuration bits.
  input wire logic [adcseq_pkg::RES_W-1:0] filter_result, // Two's-complement filter output.
  output logic conversion_start_flag, // Busy flag as software reads it.
  output logic [7:0] result_high_byte, // Result bits 12:5.
  output logic [7:0] result_low_byte, // Result bits 4:0 in bits 7:3.
  output logic conv_done_irq, // One-cycle completion request.
  output adcseq_pkg::adcseq_afe_s afe // Front-end controls.
);

  localparam logic [adcseq_pkg::CNT_W-1:0] CONV_LAST = adcseq_pkg::CNT_W'(CONV_LEN - 1);
  localparam logic [adcseq_pkg::CNT_W-1:0] PWRUP_LAST = adcseq_pkg::CNT_W'(adcseq_pkg::PWRUP_CYCLES - 1);
  localparam logic [adcseq_pkg::CNT_W-1:0] IDLE_LAST = adcseq_pkg::CNT_W'(adcseq_pkg::IDLE_CYCLES - 1);

  // Keeps only the bits that the active mode resolves; the dropped bits read zero.
  function automatic logic [adcseq_pkg::RES_W-1:0] resolve(input logic [adcseq_pkg::RES_W-1:0] raw,
                                                          input logic diff);
    logic [adcseq_pkg::RES_W-1:0] mask;
    mask = '1;
    if (diff) begin
      mask = mask << adcseq_pkg::DIFF_DROP;
    end else begin
      mask = mask << adcseq_pkg::SE_DROP;
    end
    return raw & mask;
  endfunction

  // Out-of-range channel codes fall back to the temperature sensor.
  function automatic logic [adcseq_pkg::NUM_SRC-1:0] mux_decode(input logic [3:0] ch);
    logic [adcseq_pkg::NUM_SRC-1:0] oh;
    oh = '0;
    if (ch > adcseq_pkg::TEMP_SRC) begin
      oh[adcseq_pkg::TEMP_SRC] = 1'b1;
    end else begin
      oh[ch] = 1'b1;
    end
    return oh;
  endfunction

  adcseq_pkg::adcseq_state_e state_q, state_d;
  logic [adcseq_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic busy_q, busy_d;
  logic done_q, done_d;
  logic [7:0] res_hi_q, res_hi_d;
  logic [7:0] res_lo_q, res_lo_d;
  logic [adcseq_pkg::RES_W-1:0] res_word;
  adcseq_pkg::adcseq_afe_s afe_q, afe_d;

  // Sequencer next state. Starts arriving mid-conversion are dropped on purpose.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    res_hi_d = res_hi_q;
    res_lo_d = res_lo_q;
    res_word = resolve(filter_result, cfg.input_buffer_mode_field[adcseq_pkg::BUF_DIFF_BIT]);
    unique case (state_q)
      adcseq_pkg::ST_OFF: begin
        if (start_write) begin
          state_d = adcseq_pkg::ST_PWRUP;
          cnt_d = '0;
          busy_d = 1'b1;
        end
      end
      adcseq_pkg::ST_PWRUP: begin
        if (cnt_q == PWRUP_LAST) begin
          state_d = adcseq_pkg::ST_CONV;
          cnt_d = '0;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      adcseq_pkg::ST_CONV: begin
        if (cnt_q == CONV_LAST) begin
          done_d = 1'b1;
          res_hi_d = res_word[adcseq_pkg::RES_W-1 -: 8];
          res_lo_d = {res_word[adcseq_pkg::RES_HI_LSB-1:0], 3'h0};
          cnt_d = '0;
          if (!cfg.continuous) begin
            state_d = adcseq_pkg::ST_IDLE;
            busy_d = 1'b0;
          end
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      adcseq_pkg::ST_IDLE: begin
        if (start_write) begin
          state_d = adcseq_pkg::ST_CONV;
          cnt_d = '0;
          busy_d = 1'b1;
        end else if (cnt_q == IDLE_LAST) begin
          state_d = adcseq_pkg::ST_OFF;
          cnt_d = '0;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= adcseq_pkg::ST_OFF;
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      res_hi_q <= adcseq_pkg::BYTE_RESET;
      res_lo_q <= adcseq_pkg::BYTE_RESET;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
      res_hi_q <= res_hi_d;
      res_lo_q <= res_lo_d;
    end
  end

  // Front-end controls, registered so the analog side sees clean levels.
  always_comb begin
    afe_d.mux_onehot = mux_decode(cfg.channel);
    afe_d.diff_mode = cfg.input_buffer_mode_field[adcseq_pkg::BUF_DIFF_BIT];
    afe_d.buffered = cfg.input_buffer_mode_field[adcseq_pkg::BUF_BUFFERED_BIT];
    afe_d.ref_level = {cfg.ref_level_select_high, cfg.ref_level_select_low};
    afe_d.ref_enable = |afe_d.ref_level;
    // A disabled reference is never driven out, even if software asks.
    afe_d.ref_pin_drive = cfg.ref_output_to_pin & afe_d.ref_enable;
    afe_d.pin_digital_off = cfg.pin_alt_func;
    afe_d.powered = (state_d != adcseq_pkg::ST_OFF);
    afe_d.converting = (state_d == adcseq_pkg::ST_CONV);
  end

  // Front-end control registers.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      afe_q <= '0;
    end else begin
      afe_q <= afe_d;
    end
  end

  assign conversion_start_flag = busy_q;
  assign result_high_byte = res_hi_q;
  assign result_low_byte = res_lo_q;
  assign conv_done_irq = done_q;
  assign afe = afe_q;

  // Independent span counter for the timing checks below. It restarts on every state change and on every
  // completion, so those checks do not lean on the sequencer's own counter and catch an off-by-one in it.
  logic [adcseq_pkg::CNT_W:0] span_q, span_d;

  // Span next value; it may wrap while powered down, where nothing reads it.
  always_comb begin
    if (state_d != state_q || done_d) begin
      span_d = '0;
    end else begin
      span_d = span_q + 1'b1;
    end
  end

  // Span register.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      span_q <= '0;
    end else begin
      span_q <= span_d;
    end
  end

  // A start seen while idle or off raises the busy flag on the next edge.
  property p_start_busy;
    @(posedge clk) disable iff (sys_rst)
      start_write && (state_q == adcseq_pkg::ST_OFF || state_q == adcseq_pkg::ST_IDLE) |=> busy_q;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start did not set busy");

  // Busy holds from conversion entry until the completion pulse.
  property p_busy_hold;
    @(posedge clk) disable iff (sys_rst)
      (state_q == adcseq_pkg::ST_CONV || state_q == adcseq_pkg::ST_PWRUP) |-> busy_q;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy low during conversion");

  // Completion only follows the last conversion count.
  property p_conv_len;
    @(posedge clk) disable iff (sys_rst)
      $rose(done_q) || (done_q && $past(done_q)) |-> $past(cnt_q) == CONV_LAST && $past(state_q) == adcseq_pkg::ST_CONV;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  // Power-up lasts its full count before conversion starts.
  sequence s_pwrup_end;
    state_q == adcseq_pkg::ST_PWRUP && cnt_q == PWRUP_LAST;
  endsequence
  property p_pwrup;
    @(posedge clk) disable iff (sys_rst)
      $past(state_q) == adcseq_pkg::ST_PWRUP && state_q == adcseq_pkg::ST_CONV |-> $past(cnt_q) == PWRUP_LAST;
  endproperty
  a_pwrup: assert property (p_pwrup) else $error("power-up too short");
  property p_pwrup_next;
    @(posedge clk) disable iff (sys_rst)
      s_pwrup_end |=> state_q == adcseq_pkg::ST_CONV && cnt_q == '0;
  endproperty
  a_pwrup_next: assert property (p_pwrup_next) else $error("conversion did not follow power-up");

  // The stored result matches the masked filter word at completion.
  property p_result;
    @(posedge clk) disable iff (sys_rst)
      done_q |-> {res_hi_q, res_lo_q[7:3]} ==
        $past(resolve(filter_result, cfg.input_buffer_mode_field[adcseq_pkg::BUF_DIFF_BIT]))
        && res_lo_q[2:0] == 3'h0;
  endproperty
  a_result: assert property (p_result) else $error("result bytes wrong");

  // Single-shot completion drops busy together with the request.
  sequence s_single_done;
    state_q == adcseq_pkg::ST_CONV && cnt_q == CONV_LAST && !cfg.continuous;
  endsequence
  property p_single_clear;
    @(posedge clk) disable iff (sys_rst)
      s_single_done |=> done_q && !busy_q && state_q == adcseq_pkg::ST_IDLE;
  endproperty
  a_single_clear: assert property (p_single_clear) else $error("busy not cleared at end");

  // Power-down only after the full idle count.
  property p_idle_off;
    @(posedge clk) disable iff (sys_rst)
      $past(state_q) == adcseq_pkg::ST_IDLE && state_q == adcseq_pkg::ST_OFF |-> $past(cnt_q) == IDLE_LAST;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("early power-down");

  // Continuous completion keeps converting and keeps busy high.
  property p_cont;
    @(posedge clk) disable iff (sys_rst)
      state_q == adcseq_pkg::ST_CONV && cnt_q == CONV_LAST && cfg.continuous
        |=> done_q && busy_q && state_q == adcseq_pkg::ST_CONV && cnt_q == '0;
  endproperty
  a_cont: assert property (p_cont) else $error("continuous conversion stopped");

  // A repeated start mid-conversion leaves the count running.
  property p_no_restart;
    @(posedge clk) disable iff (sys_rst)
      start_write && state_q == adcseq_pkg::ST_CONV && cnt_q != CONV_LAST |=> cnt_q == $past(cnt_q) + 1'b1;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("start disturbed conversion");

  // Reference drive never appears without an enabled reference.
  property p_ref_pin;
    @(posedge clk) disable iff (sys_rst)
      afe_q.ref_pin_drive |-> afe_q.ref_enable && afe_q.ref_level != 2'h0;
  endproperty
  a_ref_pin: assert property (p_ref_pin) else $error("reference driven while disabled");

  // Exactly one analog source is selected once out of reset.
  property p_mux;
    @(posedge clk) disable iff (sys_rst)
      $past(!sys_rst) |-> $onehot(afe_q.mux_onehot);
  endproperty
  a_mux: assert property (p_mux) else $error("mux select not one-hot");

  // Every conversion spans the full length from entering conversion to the completion edge.
  property p_conv_span;
    @(posedge clk) disable iff (sys_rst)
      done_q |-> $past(span_q) == CONV_LEN - 1;
  endproperty
  a_conv_span: assert property (p_conv_span) else $error("conversion span wrong");

  // Power-up spans its full count, measured by the independent span counter.
  property p_pwrup_span;
    @(posedge clk) disable iff (sys_rst)
      $past(state_q) == adcseq_pkg::ST_PWRUP && state_q == adcseq_pkg::ST_CONV |-> $past(span_q) == adcseq_pkg::PWRUP_CYCLES - 1;
  endproperty
  a_pwrup_span: assert property (p_pwrup_span) else $error("power-up span wrong");

  // A start while powered down powers the front end up before any conversion.
  property p_start_off;
    @(posedge clk) disable iff (sys_rst)
      start_write && state_q == adcseq_pkg::ST_OFF |=> state_q == adcseq_pkg::ST_PWRUP && afe_q.powered && !afe_q.converting;
  endproperty
  a_start_off: assert property (p_start_off) else $error("start from off skipped power-up");

  // Busy only falls together with a completion that leaves the converter idle.
  property p_busy_fall;
    @(posedge clk) disable iff (sys_rst)
      $fell(busy_q) && !$past(sys_rst) |-> done_q && state_q == adcseq_pkg::ST_IDLE;
  endproperty
  a_busy_fall: assert property (p_busy_fall) else $error("busy fell without completion");

  // Idle lasts its full count before power-down, measured by the span counter.
  property p_idle_span;
    @(posedge clk) disable iff (sys_rst)
      $past(state_q) == adcseq_pkg::ST_IDLE && state_q == adcseq_pkg::ST_OFF |-> $past(span_q) == adcseq_pkg::IDLE_CYCLES - 1;
  endproperty
  a_idle_span: assert property (p_idle_span) else $error("idle span wrong");

  // The dropped low bits read zero: two in differential mode, three in single-ended mode.
  property p_resolution;
    @(posedge clk) disable iff (sys_rst)
      done_q |-> res_lo_q[4:3] == 2'h0
        && ($past(cfg.input_buffer_mode_field[adcseq_pkg::BUF_DIFF_BIT]) || !res_lo_q[5]);
  endproperty
  a_resolution: assert property (p_resolution) else $error("resolution bits not cleared");

  // Mode and buffering follow the configuration one edge later.
  property p_afe_mode;
    @(posedge clk) disable iff (sys_rst)
      $past(!sys_rst) |-> afe_q.diff_mode == $past(cfg.input_buffer_mode_field[adcseq_pkg::BUF_DIFF_BIT])
        && afe_q.buffered == $past(cfg.input_buffer_mode_field[adcseq_pkg::BUF_BUFFERED_BIT]);
  endproperty
  a_afe_mode: assert property (p_afe_mode) else $error("input mode not applied");

  // The reference level follows the select pair, and the all-zero pair disables it.
  property p_afe_ref;
    @(posedge clk) disable iff (sys_rst)
      $past(!sys_rst) |-> afe_q.ref_level == $past({cfg.ref_level_select_high, cfg.ref_level_select_low})
        && afe_q.ref_enable == (afe_q.ref_level != 2'h0);
  endproperty
  a_afe_ref: assert property (p_afe_ref) else $error("reference select not applied");

  // Pins given to the analog function lose their digital path one edge later.
  property p_afe_pins;
    @(posedge clk) disable iff (sys_rst)
      $past(!sys_rst) |-> afe_q.pin_digital_off == $past(cfg.pin_alt_func);
  endproperty
  a_afe_pins: assert property (p_afe_pins) else $error("pin digital path not disabled");

endmodule // adcseq_core
`default_nettype wire

//--- pkg/adcseq_pkg.sv
// Constants, state encoding and carrier structs for the converter sequencer.
`default_nettype none
package adcseq_pkg;
  // Default conversion length in system clock cycles.
  localparam int unsigned CONV_CYCLES = 5129;
  // Power-up time spent before a conversion when starting from powered down.
  localparam int unsigned PWRUP_CYCLES = 40;
  // Idle time after which the converter powers itself down.
  localparam int unsigned IDLE_CYCLES = 160;
  // Counter width, wide enough for the conversion length.
  localparam int unsigned CNT_W = 13;
  // Result width and the low bits dropped per operating mode.
  localparam int unsigned RES_W = 13;
  localparam int unsigned DIFF_DROP = 2;
  localparam int unsigned SE_DROP = 3;
  // Result split: upper byte and low five bits shifted to bits 7:3.
  localparam int unsigned RES_HI_LSB = 5;
  localparam int unsigned RES_LO_SHIFT = 3;
  // Analog sources: eight pins plus the temperature sensor.
  localparam int unsigned NUM_PINS = 8;
  localparam int unsigned NUM_SRC = 9;
  localparam logic [3:0] TEMP_SRC = 4'h8;
  // Field positions inside the input buffer mode field.
  localparam int unsigned BUF_BUFFERED_BIT = 0;
  localparam int unsigned BUF_DIFF_BIT = 2;
  // Reset values.
  localparam logic [RES_W-1:0] RES_RESET = 13'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_OFF,
    ST_PWRUP,
    ST_CONV,
    ST_IDLE
  } adcseq_state_e;

  // Software configuration bits.
  typedef struct packed {
    logic continuous;
    logic [2:0] input_buffer_mode_field;
    logic ref_level_select_high;
    logic ref_level_select_low;
    logic ref_output_to_pin;
    logic [3:0] channel;
    logic [NUM_PINS-1:0] pin_alt_func;
  } adcseq_cfg_s;

  // Controls sent to the analog front end.
  typedef struct packed {
    logic [NUM_SRC-1:0] mux_onehot;
    logic diff_mode;
    logic buffered;
    logic ref_enable;
    logic [1:0] ref_level;
    logic ref_pin_drive;
    logic [NUM_PINS-1:0] pin_digital_off;
    logic powered;
    logic converting;
  } adcseq_afe_s;
endpackage
`default_nettype wire

//--- bench/adcseq_fe_model.sv
// Behavioural analog front end: multiplexer, modulator and filter as seen by the sequencer.
`timescale 1ns/100ps
`default_nettype none
module adcseq_fe_model (
  input wire logic clk, // System clock.
  input wire adcseq_pkg::adcseq_afe_s afe, // Controls from the sequencer.
  input wire logic [12:0] level, // Analog level the bench applies.
  output logic [12:0] filter_result // Filter word.
);
  logic [3:0] src;
  logic [12:0] junk_q = 13'h0AAA;
  // Decode the one-hot selection; no bit set gives a source that corrupts the word, several set bits pick the highest.
  always_comb begin
    src = 4'hF;
    for (int i = 0; i < 9; i++) if (afe.mux_onehot[i]) src = i[3:0];
  end
  // Outside a conversion the word is meaningless, so it changes every cycle instead of holding.
  always @(posedge clk) junk_q <= ~junk_q;
  assign filter_result = afe.converting ? level + {9'h000, src} : junk_q;
endmodule // adcseq_fe_model
`default_nettype wire

//--- bench/adcseq_core_tb.sv
// Self-checking testbench for the converter sequencer.
`timescale 1ns/100ps
`default_nettype none
module adcseq_core_tb;
  localparam int LEN = 20;
  typedef struct {logic [12:0] res; int due; logic busy;} adcseq_exp_s;
  logic clk = 0, sys_rst = 1, start_write = 0, conversion_start_flag, conv_done_irq;
  adcseq_pkg::adcseq_cfg_s cfg = '0;
  adcseq_pkg::adcseq_afe_s afe;
  logic [12:0] level = 13'h0000, filter_result;
  logic [7:0] result_high_byte, result_low_byte;
  int mismatches = 0, n_checks = 0, cyc = 0, seed = 46751;
  adcseq_exp_s q[$];
  adcseq_exp_s e;
  adcseq_core #(.CONV_LEN(LEN)) adcseq_core_inst (.clk(clk), .sys_rst(sys_rst), .start_write(start_write),
    .cfg(cfg), .filter_result(filter_result), .conversion_start_flag(conversion_start_flag),
    .result_high_byte(result_high_byte), .result_low_byte(result_low_byte), .conv_done_irq(conv_done_irq),
    .afe(afe));
  adcseq_fe_model adcseq_fe_model_inst (.clk(clk), .afe(afe), .level(level), .filter_result(filter_result));
  // Clock and a cycle count used to time completions.
  initial begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  function automatic logic [12:0] exp_res();
    logic [12:0] v;
    v = level + ((cfg.channel > 4'h8) ? 13'h0008 : {9'h000, cfg.channel});
    return v & (cfg.input_buffer_mode_field[2] ? 13'h1FFC : 13'h1FF8);
  endfunction
  task automatic note(input int lat, input logic busy);
    q.push_back('{exp_res(), cyc + lat, busy});
  endtask
  // One-cycle start pulse; the note is made half a cycle before the taking edge, hence one extra cycle.
  task automatic go(input int lat);
    @(negedge clk);
    start_write = 1;
    note(lat + 1, cfg.continuous);
    @(negedge clk);
    start_write = 0;
  endtask
  // Bounded wait until every noted completion has been seen.
  task automatic drain();
    for (int i = 0; i < 200; i++) begin
      @(negedge clk);
      #1;
      if (q.size() == 0) break;
    end
    chk("pending completions", 0, q.size());
  endtask
  // Completion watcher: the oldest note is compared when the request pulse appears.
  always @(negedge clk) begin
    if (conv_done_irq === 1'b1) begin
      if (q.size() == 0) begin
        chk("unexpected completion", 0, 1);
      end else begin
        e = q.pop_front();
        chk("completion cycle", e.due, cyc);
        chk("high byte", e.res[12:5], result_high_byte);
        chk("low byte", {e.res[4:0], 3'h0}, result_low_byte);
        chk("busy at completion", e.busy, conversion_start_flag);
      end
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // A hang is cut short well after the few hundred cycles the tests need.
  initial begin
    #20000;
    mismatches++;
    close_out();
  end
  initial begin
    repeat (3) @(negedge clk);
    sys_rst = 0;
    // Random configurations must reach the front-end controls one edge later.
    for (int i = 0; i < 12; i++) begin
      cfg = adcseq_pkg::adcseq_cfg_s'(19'($random(seed)));
      cfg.continuous = 0;
      @(negedge clk);
      chk("diff", cfg.input_buffer_mode_field[2], afe.diff_mode);
      chk("buffered", cfg.input_buffer_mode_field[0], afe.buffered);
      chk("ref enable", |{cfg.ref_level_select_high, cfg.ref_level_select_low}, afe.ref_enable);
      chk("ref level", {cfg.ref_level_select_high, cfg.ref_level_select_low}, afe.ref_level);
      chk("ref pin", cfg.ref_output_to_pin & |{cfg.ref_level_select_high, cfg.ref_level_select_low},
        afe.ref_pin_drive);
      chk("pin off", cfg.pin_alt_func, afe.pin_digital_off);
      chk("mux", 9'h001 << ((cfg.channel > 4'h8) ? 4'h8 : cfg.channel), afe.mux_onehot);
    end
    $display("test config done");
    // From powered down, differential, with a repeated start that must be ignored.
    cfg.input_buffer_mode_field = 3'h5;
    cfg.channel = 4'h3;
    level = 13'($random(seed));
    go(LEN + 40);
    repeat (50) @(negedge clk);
    chk("busy", 1, conversion_start_flag);
    chk("converting", 1, afe.converting);
    start_write = 1;
    @(negedge clk);
    start_write = 0;
    drain();
    $display("test power-up done");
    // Back to back from idle, single-ended, temperature sensor source.
    cfg.input_buffer_mode_field = 3'h1;
    cfg.channel = 4'hB;
    level = 13'($random(seed));
    go(LEN);
    drain();
    $display("test idle start done");
    // Continuous run of three conversions with a new level before the second and the third, stopped in the third.
    cfg.continuous = 1;
    go(LEN);
    for (int i = 0; i < 2; i++) begin
      drain();
      level = 13'($random(seed));
      cfg.continuous = (i == 0);
      note(LEN, cfg.continuous);
    end
    drain();
    $display("test continuous done");
    // Idle power-down, then a start that pays the power-up time again.
    repeat (150) @(negedge clk);
    chk("powered", 1, afe.powered);
    repeat (15) @(negedge clk);
    chk("powered", 0, afe.powered);
    go(LEN + 40);
    drain();
    $display("test power-down done");
    close_out();
  end
endmodule // adcseq_core_tb
`default_nettype wire
